// ### dv/port9_pin_function_select_tb_top.sv
// Testbench for the port 9 pin mode register and pin mux.
module port9_pin_function_select_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic [15:0] pdo = 16'h0, poe = 16'hffff, afo = 16'h0, afe = 16'hffff, pin = 16'h0;
	wire awready, wready, bvalid, arready, rvalid;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [15:0] po, pe, pdi, afi, msel;
	int num_errors = 0, cmp_count = 0;
	always #25 aclk = ~aclk;
	ppfs_top uut
	(
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .port_data_out(pdo), .port_out_en_n(poe),
		.alt_function_out(afo), .alt_function_out_en_n(afe), .port9_pin_n_in(pin),
		.port9_pin_n_out(po), .port9_pin_n_out_en_n(pe), .port_data_in(pdi),
		.alt_function_in(afi), .pin_mode_select_bit(msel)
	);
	task automatic chk(input [31:0] g, input [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic end_of_test;
		if (num_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic tmo(input int n);
		if (n >= 50)
		begin
			num_errors++;
			end_of_test;
		end
	endtask
	task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] r);
		int n = 0;
		bit ta = 0, tw = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (!ta && awready)
			begin
				ta = 1;
				awvalid <= 1'b0;
			end
			if (!tw && wready)
			begin
				tw = 1;
				wvalid <= 1'b0;
			end
		end while (!bvalid && n < 50);
		tmo(n);
		chk({30'h0, bresp}, {30'h0, r});
	endtask
	task automatic rd(input [7:0] a, input [31:0] e, input [1:0] r);
		int n = 0;
		bit t = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (!t && arready)
			begin
				t = 1;
				arvalid <= 1'b0;
			end
		end while (!rvalid && n < 50);
		tmo(n);
		chk(rdata, e);
		chk({30'h0, rresp}, {30'h0, r});
	endtask
	// Pins settle within three edges of a mode or pad change.
	task automatic pins(input [15:0] m);
		repeat (4) @(posedge aclk);
		chk({16'h0, po}, {16'h0, (m & afo) | (~m & pdo)});
		chk({16'h0, pe}, {16'h0, (m & afe) | (~m & poe)});
		chk({16'h0, pdi}, {16'h0, pin});
		chk({16'h0, afi}, {16'h0, pin & m});
		chk({16'h0, msel}, {16'h0, m});
	endtask
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		pdo <= 16'h1234;
		poe <= 16'h0f0f;
		afo <= 16'habcd;
		afe <= 16'h00ff;
		pin <= 16'hc3c3;
		@(posedge aclk);
		rd(8'h00, 32'h0, 2'h0);
		pins(16'h0000);
		wr(8'h00, 32'hffff, 4'h3, 2'h0);
		rd(8'h00, 32'hffff, 2'h0);
		rd(8'h04, 32'hff, 2'h0);
		pins(16'hffff);
		wr(8'h04, 32'h5a, 4'h1, 2'h0);
		wr(8'h08, 32'h3c, 4'h1, 2'h0);
		rd(8'h00, 32'h3c5a, 2'h0);
		rd(8'h08, 32'h3c, 2'h0);
		wr(8'h0c, 32'h19, 4'h1, 2'h0);
		wr(8'h0c, 32'h01, 4'h1, 2'h0);
		rd(8'h0c, 32'h01, 2'h0);
		rd(8'h00, 32'h3e58, 2'h0);
		pins(16'h3e58);
		rd(8'h10, 32'h0000c3c3, 2'h0);
		wr(8'h14, 32'h0, 4'hf, 2'h2);
		wr(8'h10, 32'h0, 4'hf, 2'h2);
		rd(8'h14, 32'h0, 2'h2);
		rd(8'h00, 32'h3e58, 2'h0);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(8'h00, 32'h0, 2'h0);
		pins(16'h0000);
		end_of_test;
	end
endmodule

// ### dv/ppfs_chk.sv
// Checker for the pin mode register and the per-pin function mux.
module ppfs_chk
(
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_bvalid,
	input wire [15:0] port_data_out,
	input wire [15:0] port_out_en_n,
	input wire [15:0] alt_function_out,
	input wire [15:0] alt_function_out_en_n,
	input wire [15:0] port9_pin_n_out,
	input wire [15:0] port9_pin_n_out_en_n,
	input wire [15:0] alt_function_in,
	input wire [15:0] pin_mode_select_bit
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [7:0] ar_q;
	wire [15:0] m = pin_mode_select_bit;
	wire [15:0] exp_o = (m & alt_function_out) | (~m & port_data_out);
	wire [15:0] exp_e = (m & alt_function_out_en_n) | (~m & port_out_en_n);
	always @(posedge aclk)
		if (s_axi_arvalid && s_axi_arready)
			ar_q <= s_axi_araddr;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_reset_zero: assert property ($rose(aresetn) |-> m == 16'h0000)
		else $error("mode not clear after reset");
	chk_pin_output: assert property ($past(aresetn) |-> port9_pin_n_out == $past(exp_o))
		else $error("pin output source wrong");
	chk_pin_enable: assert property ($past(aresetn) |-> port9_pin_n_out_en_n == $past(exp_e))
		else $error("pin enable source wrong");
	chk_alt_input: assert property ($past(aresetn) |-> (alt_function_in & ~$past(m)) == 16'h0000)
		else $error("alternate input leaks in port mode");
	chk_mode_moment: assert property (!$stable(m) |-> $rose(s_axi_bvalid))
		else $error("mode changed without write response");
	chk_word_read: assert property ($rose(s_axi_rvalid) && ar_q == 8'h00 |->
		s_axi_rdata == {16'h0000, $past(m)})
		else $error("word read wrong");
	chk_lower_read: assert property ($rose(s_axi_rvalid) && ar_q == 8'h04 |->
		s_axi_rdata == {24'h000000, $past(m[7:0])})
		else $error("lower byte read wrong");
	chk_upper_read: assert property ($rose(s_axi_rvalid) && ar_q == 8'h08 |->
		s_axi_rdata == {24'h000000, $past(m[15:8])})
		else $error("upper byte read wrong");
endmodule

bind ppfs_top ppfs_chk chk_i (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_bvalid, .port_data_out, .port_out_en_n,
	.alt_function_out, .alt_function_out_en_n, .port9_pin_n_out, .port9_pin_n_out_en_n,
	.alt_function_in, .pin_mode_select_bit);

// ### rtl/ppfs_consts.vh
// Constants for the port 9 pin function select block.
`ifndef PPFS_CONSTS_VH
`define PPFS_CONSTS_VH

`define PPFS_PIN_COUNT        16
`define PPFS_ADDR_W           8

`define PPFS_OFS_MODE_WORD    8'h00
`define PPFS_OFS_MODE_LOWER   8'h04
`define PPFS_OFS_MODE_UPPER   8'h08
`define PPFS_OFS_MODE_BIT     8'h0c
`define PPFS_OFS_PIN_LEVEL    8'h10

`define PPFS_SEL_MODE_WORD    3'h0
`define PPFS_SEL_MODE_LOWER   3'h1
`define PPFS_SEL_MODE_UPPER   3'h2
`define PPFS_SEL_MODE_BIT     3'h3
`define PPFS_SEL_PIN_LEVEL    3'h4
`define PPFS_SEL_NONE         3'h7

`define PPFS_MODE_RESET       16'h0000
`define PPFS_BITOP_RESET      4'h0

`define PPFS_BITOP_IDX_MSB    2
`define PPFS_BITOP_UPPER_POS  3
`define PPFS_BITOP_VALUE_POS  4

`define PPFS_RESP_OKAY        2'h0
`define PPFS_RESP_SLVERR      2'h2

`endif

// ### rtl/ppfs_pin_cell.v
// One pin of the port: selects plain port or alternate function and registers the pad side.
module ppfs_pin_cell
(
	input  wire aclk,
	input  wire aresetn,
	input  wire mode_sel,
	input  wire port_dout,
	input  wire port_oe_n,
	input  wire alt_dout,
	input  wire alt_oe_n,
	input  wire pin_level,
	output reg  pin_out,
	output reg  pin_out_en_n,
	output reg  port_din,
	output reg  alt_din
);

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_out      <= 1'b0;
			pin_out_en_n <= 1'b1;
			port_din     <= 1'b0;
			alt_din      <= 1'b0;
		end
		else
		begin
			if (mode_sel)
			begin
				pin_out      <= alt_dout;
				pin_out_en_n <= alt_oe_n;
			end
			else
			begin
				pin_out      <= port_dout;
				pin_out_en_n <= port_oe_n;
			end
			// The port always reads the pin; alternate inputs idle low in port mode.
			port_din <= pin_level;
			alt_din  <= mode_sel & pin_level;
		end
	end

endmodule

// ### rtl/ppfs_top.v
// Port 9 pin mode control register with AXI4-Lite access and the per-pin function mux.
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`include "ppfs_consts.vh"

module ppfs_top
(
	input  wire        aclk,
	input  wire        aresetn,

	input  wire [7:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,

	input  wire [15:0] port_data_out,
	input  wire [15:0] port_out_en_n,
	input  wire [15:0] alt_function_out,
	input  wire [15:0] alt_function_out_en_n,
	input  wire [15:0] port9_pin_n_in,
	output wire [15:0] port9_pin_n_out,
	output wire [15:0] port9_pin_n_out_en_n,
	output wire [15:0] port_data_in,
	output wire [15:0] alt_function_in,
	output wire [15:0] pin_mode_select_bit
);

	localparam PINS = `PPFS_PIN_COUNT;

	reg  [15:0] port9_pin_mode_control_reg;
	reg  [15:0] port9_pin_mode_control_next;
	reg  [3:0]  bitop_sel_reg;
	reg  [3:0]  bitop_sel_next;
	reg  [15:0] pin_sync1_reg;
	reg  [15:0] pin_sync2_reg;
	reg  [7:0]  aw_addr_reg;
	reg         aw_held_reg;
	reg  [31:0] w_data_reg;
	reg  [3:0]  w_strb_reg;
	reg         w_held_reg;
	wire        do_write;
	wire [2:0]  wr_sel;
	wire [2:0]  rd_sel;
	wire [3:0]  bit_pos;

	// Maps a byte address to a register selector; unmapped gives the none code.
	function [2:0] ppfs_decode;
		input [7:0] addr;
		begin
			case (addr)
				`PPFS_OFS_MODE_WORD:  ppfs_decode = `PPFS_SEL_MODE_WORD;
				`PPFS_OFS_MODE_LOWER: ppfs_decode = `PPFS_SEL_MODE_LOWER;
				`PPFS_OFS_MODE_UPPER: ppfs_decode = `PPFS_SEL_MODE_UPPER;
				`PPFS_OFS_MODE_BIT:   ppfs_decode = `PPFS_SEL_MODE_BIT;
				`PPFS_OFS_PIN_LEVEL:  ppfs_decode = `PPFS_SEL_PIN_LEVEL;
				default:              ppfs_decode = `PPFS_SEL_NONE;
			endcase
		end
	endfunction

	// Tells whether a selector names a register that takes writes.
	function ppfs_writable;
		input [2:0] sel;
		begin
			ppfs_writable = (sel == `PPFS_SEL_MODE_WORD) ||
				(sel == `PPFS_SEL_MODE_LOWER) ||
				(sel == `PPFS_SEL_MODE_UPPER) || (sel == `PPFS_SEL_MODE_BIT);
		end
	endfunction

	// A write commits once address and data are both held and the last answer is gone.
	assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
	assign wr_sel   = ppfs_decode(aw_addr_reg);
	assign rd_sel   = ppfs_decode(s_axi_araddr);
	assign bit_pos  = {w_data_reg[`PPFS_BITOP_UPPER_POS],
		w_data_reg[`PPFS_BITOP_IDX_MSB:0]};

	// Pin levels come from outside the clock domain.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_sync1_reg <= 16'h0000;
			pin_sync2_reg <= 16'h0000;
		end
		else
		begin
			pin_sync1_reg <= port9_pin_n_in;
			pin_sync2_reg <= pin_sync1_reg;
		end
	end

	// Next value of the mode register for the pending write.
	always @*
	begin
		port9_pin_mode_control_next = port9_pin_mode_control_reg;
		bitop_sel_next              = bitop_sel_reg;
		if (do_write)
		begin
			case (wr_sel)
				`PPFS_SEL_MODE_WORD:
				begin
					if (w_strb_reg[0])
						port9_pin_mode_control_next[7:0] = w_data_reg[7:0];
					if (w_strb_reg[1])
						port9_pin_mode_control_next[15:8] = w_data_reg[15:8];
				end
				`PPFS_SEL_MODE_LOWER:
				begin
					if (w_strb_reg[0])
						port9_pin_mode_control_next[7:0] = w_data_reg[7:0];
				end
				`PPFS_SEL_MODE_UPPER:
				begin
					if (w_strb_reg[0])
						port9_pin_mode_control_next[15:8] = w_data_reg[7:0];
				end
				`PPFS_SEL_MODE_BIT:
				begin
					if (w_strb_reg[0])
					begin
						bitop_sel_next = bit_pos;
						port9_pin_mode_control_next[bit_pos] =
							w_data_reg[`PPFS_BITOP_VALUE_POS];
					end
				end
				default:
				begin
					port9_pin_mode_control_next = port9_pin_mode_control_reg;
				end
			endcase
		end
	end

	// Write channels: address and data are taken independently, then answered together.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			port9_pin_mode_control_reg <= `PPFS_MODE_RESET;
			bitop_sel_reg              <= `PPFS_BITOP_RESET;
			s_axi_awready              <= 1'b0;
			s_axi_wready               <= 1'b0;
			s_axi_bvalid               <= 1'b0;
			s_axi_bresp                <= `PPFS_RESP_OKAY;
			aw_addr_reg                <= 8'h00;
			aw_held_reg                <= 1'b0;
			w_data_reg                 <= 32'h00000000;
			w_strb_reg                 <= 4'h0;
			w_held_reg                 <= 1'b0;
		end
		else
		begin
			port9_pin_mode_control_reg <= port9_pin_mode_control_next;
			bitop_sel_reg              <= bitop_sel_next;

			if (s_axi_awready && s_axi_awvalid)
			begin
				aw_addr_reg   <= s_axi_awaddr;
				aw_held_reg   <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			else if (!aw_held_reg && !s_axi_bvalid)
			begin
				s_axi_awready <= 1'b1;
			end

			if (s_axi_wready && s_axi_wvalid)
			begin
				w_data_reg   <= s_axi_wdata;
				w_strb_reg   <= s_axi_wstrb;
				w_held_reg   <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			else if (!w_held_reg && !s_axi_bvalid)
			begin
				s_axi_wready <= 1'b1;
			end

			if (do_write)
			begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (ppfs_writable(wr_sel))
					s_axi_bresp <= `PPFS_RESP_OKAY;
				else
					s_axi_bresp <= `PPFS_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel: one read at a time, data one cycle after the address is taken.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `PPFS_RESP_OKAY;
		end
		else if (s_axi_arready && s_axi_arvalid)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `PPFS_RESP_OKAY;
			case (rd_sel)
				`PPFS_SEL_MODE_WORD:
				begin
					s_axi_rdata <= {16'h0000, port9_pin_mode_control_reg};
				end
				`PPFS_SEL_MODE_LOWER:
				begin
					s_axi_rdata <= {24'h000000, port9_pin_mode_control_reg[7:0]};
				end
				`PPFS_SEL_MODE_UPPER:
				begin
					s_axi_rdata <= {24'h000000, port9_pin_mode_control_reg[15:8]};
				end
				`PPFS_SEL_MODE_BIT:
				begin
					s_axi_rdata <= {27'h0000000,
						port9_pin_mode_control_reg[bitop_sel_reg], bitop_sel_reg};
				end
				`PPFS_SEL_PIN_LEVEL:
				begin
					// Synchronised pad levels; this word is read only.
					s_axi_rdata <= {16'h0000, pin_sync2_reg};
				end
				default:
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `PPFS_RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
		end
		else if (!s_axi_rvalid)
		begin
			s_axi_arready <= 1'b1;
		end
	end

	assign pin_mode_select_bit = port9_pin_mode_control_reg;

	genvar gi;
	generate
		for (gi = 0; gi < PINS; gi = gi + 1)
		begin : g_pin
			ppfs_pin_cell u_cell
			(
				.aclk         (aclk),
				.aresetn      (aresetn),
				.mode_sel     (port9_pin_mode_control_reg[gi]),
				.port_dout    (port_data_out[gi]),
				.port_oe_n    (port_out_en_n[gi]),
				.alt_dout     (alt_function_out[gi]),
				.alt_oe_n     (alt_function_out_en_n[gi]),
				.pin_level    (pin_sync2_reg[gi]),
				.pin_out      (port9_pin_n_out[gi]),
				.pin_out_en_n (port9_pin_n_out_en_n[gi]),
				.port_din     (port_data_in[gi]),
				.alt_din      (alt_function_in[gi])
			);
		end
	endgenerate

endmodule
